// ==== verilog/mode_port_defines.vh ====
`ifndef MODE_PORT_DEFINES_VH
`define MODE_PORT_DEFINES_VH

`define ADDR_W            5
`define DATA_W            8
`define REG_COUNT         32
`define CMD_RW_BIT        7
`define CMD_LEN_HI_BIT    6
`define CMD_LEN_LO_BIT    5
`define CMD_ADDR_MSB      4
`define CMD_BITS          4'h8
`define BIT_CNT_LAST      3'h7
`define CLK_PERIOD_NS     10
`define STANDBY_HOLD_NS   1000
`define SERIAL_WINDOW_NS  2000

`define LEN_CODE_ONE    2'h0
`define LEN_CODE_TWO    2'h1
`define LEN_CODE_FOUR   2'h2
`define BYTES_ONE       4'h1
`define BYTES_TWO       4'h2
`define BYTES_FOUR      4'h4
`define BYTES_EIGHT     4'h8

`endif

// ==== verilog/pin_sync.v ====
`timescale 1ns/10ps
// two-stage synchroniser; the first stage feeds only the second
module pin_sync
#(
  // idle level of the pin, so leaving reset shows no false edge
  parameter RESET_LEVEL = 1'b1
)
(
  input  wire clk,
  input  wire rst,
  input  wire pin_in,
  output reg  pin_out
);
  reg meta;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta    <= RESET_LEVEL;
      pin_out <= RESET_LEVEL;
    end
    else
    begin
      meta    <= pin_in;
      pin_out <= meta;
    end
  end
endmodule

// ==== verilog/reg_space.v ====
`timescale 1ns/10ps
`include "mode_port_defines.vh"
// register space of the serial port; contents are meaning-free here
module reg_space
#(
  parameter AW = `ADDR_W,
  parameter DW = `DATA_W,
  parameter N  = `REG_COUNT
)
(
  input  wire          clk,
  input  wire          rst,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output wire [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:N-1];
  integer i;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < N; i = i + 1)
        mem[i] <= {DW{1'b0}};
    end
    else if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  assign rd_data = mem[rd_addr];
endmodule

// ==== verilog/shared_pin_mode_and_serial_port.v ====
`timescale 1ns/10ps
`include "mode_port_defines.vh"
module shared_pin_mode_and_serial_port
#(
  parameter STANDBY_HOLD_NS  = `STANDBY_HOLD_NS,
  parameter SERIAL_WINDOW_NS = `SERIAL_WINDOW_NS
)
(
  input  wire clk,
  input  wire rst,
  input  wire mode_clk_pin,
  input  wire tx_pin_in,
  output reg  tx_pin_out,
  output reg  tx_pin_oe,
  output reg  lin_tx,
  output reg  standby,
  output reg  serial_mode,
  output reg  busy
);
  // hold rounds up so standby never comes early; the window rounds down
  localparam HOLD_CYC = (STANDBY_HOLD_NS + `CLK_PERIOD_NS - 1)
                        / `CLK_PERIOD_NS;
  localparam WIN_CYC  = SERIAL_WINDOW_NS / `CLK_PERIOD_NS;
  localparam CW = 16;
  localparam [CW-1:0] HOLD_CNT = HOLD_CYC[CW-1:0];
  localparam [CW-1:0] WIN_CNT  = (WIN_CYC < 1) ? 16'h0001
                                                : WIN_CYC[CW-1:0];

  // binary state codes
  localparam [2:0] ST_NORMAL  = 3'h0;
  localparam [2:0] ST_WAIT    = 3'h1;
  localparam [2:0] ST_STANDBY = 3'h2;
  localparam [2:0] ST_CMD     = 3'h3;
  localparam [2:0] ST_WDATA   = 3'h4;
  localparam [2:0] ST_RDATA   = 3'h5;

  wire en_s;
  wire tx_s;
  reg  en_d;
  reg  tx_d;
  reg  [2:0]          state;
  reg  [CW-1:0]       timer;
  reg  [3:0]          bit_cnt;
  reg  [7:0]          shreg;
  reg  [`ADDR_W-1:0]  addr;
  reg  [3:0]          bytes_left;
  reg                 is_read;
  reg                 wr_en;
  reg  [`DATA_W-1:0]  wr_data;
  reg  [`ADDR_W-1:0]  wr_addr;
  wire [`DATA_W-1:0]  rd_data;
  wire en_rise = en_s & ~en_d;
  wire en_fall = ~en_s & en_d;
  wire tx_fall = ~tx_s & tx_d;
  wire [`DATA_W-1:0]  next_shreg = {shreg[`DATA_W-2:0], tx_s};
  // command fields as they stand once the eighth bit is in
  wire                cmd_rw     = next_shreg[`CMD_RW_BIT];
  wire [1:0]          cmd_len    = {next_shreg[`CMD_LEN_HI_BIT],
                                    next_shreg[`CMD_LEN_LO_BIT]};
  wire [`ADDR_W-1:0]  cmd_addr   = next_shreg[`CMD_ADDR_MSB:0];
  wire                byte_done  = (bit_cnt == {1'b0, `BIT_CNT_LAST});
  wire                last_byte  = (bytes_left == `BYTES_ONE);
  wire                in_window  = (timer < WIN_CNT);
  wire                hold_done  = (timer >= HOLD_CNT - 16'h0001);
  wire [CW-1:0]       next_timer = timer + 16'h0001;
  // five-bit sum, so the address wraps instead of spilling over
  wire [`ADDR_W-1:0]  next_addr  = addr + 5'h01;

  pin_sync #(.RESET_LEVEL(1'b1)) u_sync_en
  (
    .clk     (clk),
    .rst     (rst),
    .pin_in  (mode_clk_pin),
    .pin_out (en_s)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_sync_tx
  (
    .clk     (clk),
    .rst     (rst),
    .pin_in  (tx_pin_in),
    .pin_out (tx_s)
  );

  // combinational read port, so a byte is ready at its first rising edge
  reg_space u_regs
  (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (addr),
    .rd_data (rd_data)
  );

  // length code to byte count
  function [3:0] len_bytes;
    input [1:0] code;
    begin
      case (code)
        `LEN_CODE_ONE:  len_bytes = `BYTES_ONE;
        `LEN_CODE_TWO:  len_bytes = `BYTES_TWO;
        `LEN_CODE_FOUR: len_bytes = `BYTES_FOUR;
        default:        len_bytes = `BYTES_EIGHT;
      endcase
    end
  endfunction

  // edge detectors start at the idle high level, so reset shows no edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      en_d <= 1'b1;
      tx_d <= 1'b1;
    end
    else
    begin
      en_d <= en_s;
      tx_d <= tx_s;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state       <= ST_NORMAL;
      timer       <= {CW{1'b0}};
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      addr        <= {`ADDR_W{1'b0}};
      bytes_left  <= 4'h0;
      is_read     <= 1'b0;
      wr_en       <= 1'b0;
      wr_data     <= 8'h00;
      wr_addr     <= {`ADDR_W{1'b0}};
      tx_pin_out  <= 1'b1;
      tx_pin_oe   <= 1'b0;
      lin_tx      <= 1'b1;
      standby     <= 1'b0;
      serial_mode <= 1'b0;
      busy        <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      case (state)
        ST_NORMAL:
        begin
          lin_tx <= tx_s;
          // with the pin high nothing here ever fires
          if (en_fall)
          begin
            timer <= {CW{1'b0}};
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // lin path stays open until the decision is made
          lin_tx <= tx_s;
          timer  <= next_timer;
          // hold is shorter than the window, so a late fall finds standby
          if (en_s)
            state <= ST_NORMAL;
          // the fall cycle overrides lin_tx, so the bus never sees it
          else if (tx_fall && in_window)
          begin
            state       <= ST_CMD;
            serial_mode <= 1'b1;
            busy        <= 1'b1;
            lin_tx      <= 1'b1;
            bit_cnt     <= 4'h0;
          end
          // a pin low without a fall in the window is lin traffic
          else if (!tx_s)
            state <= ST_NORMAL;
          else if (hold_done)
          begin
            state   <= ST_STANDBY;
            standby <= 1'b1;
            lin_tx  <= 1'b1;
          end
        end
        ST_STANDBY:
        begin
          // only a rising mode pin wakes; no timeout leaves this state
          if (en_rise)
          begin
            standby <= 1'b0;
            state   <= ST_NORMAL;
          end
        end
        ST_CMD:
        begin
          // sample on serial clock falling edge
          if (en_fall)
          begin
            shreg   <= next_shreg;
            bit_cnt <= bit_cnt + 4'h1;
            // the byte is whole only at this edge, so fields use next_shreg
            if (byte_done)
            begin
              bit_cnt    <= 4'h0;
              is_read    <= cmd_rw;
              bytes_left <= len_bytes(cmd_len);
              addr       <= cmd_addr;
              state      <= cmd_rw ? ST_RDATA : ST_WDATA;
            end
          end
        end
        ST_WDATA:
        begin
          if (en_fall)
          begin
            shreg   <= next_shreg;
            bit_cnt <= bit_cnt + 4'h1;
            if (byte_done)
            begin
              bit_cnt    <= 4'h0;
              wr_en      <= 1'b1;
              wr_data    <= next_shreg;
              wr_addr    <= addr;
              addr       <= next_addr;
              bytes_left <= bytes_left - 4'h1;
              if (last_byte)
              begin
                state       <= ST_NORMAL;
                serial_mode <= 1'b0;
                busy        <= 1'b0;
              end
            end
          end
        end
        ST_RDATA:
        begin
          // drive on rising edge; load byte at its first bit
          if (en_rise)
          begin
            tx_pin_oe <= is_read;
            if (bit_cnt == 4'h0)
            begin
              tx_pin_out <= rd_data[`DATA_W-1];
              shreg      <= {rd_data[`DATA_W-2:0], 1'b0};
            end
            else
            begin
              tx_pin_out <= shreg[`DATA_W-1];
              shreg      <= {shreg[`DATA_W-2:0], 1'b0};
            end
          end
          // tx_pin_out keeps its last bit after release; the pull-up rules
          if (en_fall)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (byte_done)
            begin
              bit_cnt    <= 4'h0;
              addr       <= next_addr;
              bytes_left <= bytes_left - 4'h1;
              if (last_byte)
              begin
                state       <= ST_NORMAL;
                serial_mode <= 1'b0;
                busy        <= 1'b0;
                tx_pin_oe   <= 1'b0;
              end
            end
          end
        end
        default:
          state <= ST_NORMAL;
      endcase
    end
  end
  // no path starts a frame on its own; every step waits on pin edges
  // limitation: a frame cut short is only left through rst
endmodule

// ==== tb/mode_port_asserts.sv ====
`timescale 1ns/10ps
module mode_port_checker
#(
  parameter STANDBY_HOLD_NS = 1000
)
(
  input wire clk,
  input wire rst,
  input wire mode_clk_pin,
  input wire tx_pin_in,
  input wire tx_pin_out,
  input wire tx_pin_oe,
  input wire lin_tx,
  input wire standby,
  input wire serial_mode,
  input wire busy
);
  reg [7:0] low_run;
  reg [3:0] high_run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // saturating run lengths of the raw pins, so long waits need no repetition
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      low_run <= 8'h0;
      high_run <= 4'h0;
    end
    else
    begin
      low_run <= (mode_clk_pin | ~tx_pin_in) ? 8'h0 :
                 low_run + {7'h0, ~&low_run};
      high_run <= mode_clk_pin ? high_run + {3'h0, ~&high_run} : 4'h0;
    end
  sequence s_port_idle;
    !serial_mode && !tx_pin_oe;
  endsequence
  a_busy_tracks:
    assert property (busy == serial_mode) else $error("busy mismatch");
  a_drive_in_port:
    assert property (tx_pin_oe |-> serial_mode) else $error("stray drive");
  a_lin_follows:
    assert property ((mode_clk_pin && !standby && $stable(tx_pin_in))[*6]
      |-> lin_tx == tx_pin_in) else $error("lin_tx not following");
  a_standby_hold:
    assert property ($rose(standby) |-> low_run >= STANDBY_HOLD_NS / 10)
    else $error("standby too early");
  a_standby_exit:
    assert property (standby && $rose(mode_clk_pin) |-> ##[1:8] !standby)
    else $error("standby kept");
  a_high_normal:
    assert property (high_run == 4'hf |-> !standby && !serial_mode)
    else $error("left normal mode");
  a_port_entry:
    assert property ($rose(serial_mode) |-> !mode_clk_pin && !tx_pin_in)
    else $error("bad port entry");
  a_oe_on_high:
    assert property ($rose(tx_pin_oe) |-> mode_clk_pin)
    else $error("drive not on rising clock");
  a_port_exit:
    assert property ($fell(serial_mode) |-> !mode_clk_pin ##1 s_port_idle)
    else $error("bad port exit");
endmodule
bind shared_pin_mode_and_serial_port mode_port_checker
  #(.STANDBY_HOLD_NS(STANDBY_HOLD_NS)) mode_port_checker_inst
(
  .clk(clk), .rst(rst), .mode_clk_pin(mode_clk_pin), .tx_pin_in(tx_pin_in),
  .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .lin_tx(lin_tx),
  .standby(standby), .serial_mode(serial_mode), .busy(busy)
);

// ==== tb/mcu_master.sv ====
`timescale 1ns/10ps
module mcu_master
(
  input  wire clk,
  input  wire sda_in,
  output reg  scl = 1'b1,
  output reg  sda = 1'b1,
  output reg  sda_oe = 1'b1
);
  task pins(input e, input t);
  begin
    scl <= e;
    sda <= t;
    sda_oe <= 1'b1;
    @(posedge clk);
  end
  endtask
  // only this side opens a frame; clock stands high between frames
  task frame(input rw, input [1:0] lc, input [4:0] a, input [63:0] wd,
             output [63:0] rd);
    reg [7:0] sh;
    integer   i, k;
  begin
    rd = 64'h0;
    pins(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    sda <= 1'b0;
    repeat (12) @(posedge clk);
    for (i = 0; i <= (1 << lc); i = i + 1)
      for (k = 7; k >= 0; k = k - 1)
      begin
        sh = i ? wd[8*i-8 +: 8] : {rw, lc, a};
        scl <= 1'b1;
        sda <= sh[k];
        sda_oe <= !(rw && i);
        repeat (4) @(posedge clk);
        if (i)
          rd[8*i-8+k] = sda_in;
        scl <= 1'b0;
        repeat (4) @(posedge clk);
      end
    repeat (4) @(posedge clk);
    pins(1'b1, 1'b1);
    repeat (8) @(posedge clk);
  end
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  reg     clk = 1'b0;
  reg     rst = 1'b1;
  wire    scl, sda, sda_oe, tx_wire, tx_pin_out, tx_pin_oe;
  wire    lin_tx, standby, serial_mode, busy;
  integer n_errors = 0;
  integer comparisons = 0;
  integer cycles = 0;
  // the transmit pin has a pull-up, so a released pin reads high
  assign tx_wire = tx_pin_oe ? tx_pin_out : (sda_oe ? sda : 1'b1);
  shared_pin_mode_and_serial_port shared_pin_mode_and_serial_port_inst
  (
    .clk(clk), .rst(rst), .mode_clk_pin(scl), .tx_pin_in(tx_wire),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .lin_tx(lin_tx),
    .standby(standby), .serial_mode(serial_mode), .busy(busy)
  );
  mcu_master mcu_master_inst
  (
    .clk(clk), .sda_in(tx_wire), .scl(scl), .sda(sda), .sda_oe(sda_oe)
  );
  always #5 clk = ~clk;
  task check(input [63:0] what, input [63:0] exp, input [63:0] got);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("unexpected %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task summarize;
  begin
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task test_modes;
  begin
    mcu_master_inst.pins(1'b1, 1'b0);
    repeat (8) @(posedge clk);
    check("lin_tx", 64'h0, lin_tx);
    mcu_master_inst.pins(1'b1, 1'b1);
    repeat (300) @(posedge clk);
    check("standby", 64'h0, standby);
    mcu_master_inst.pins(1'b0, 1'b1);
    repeat (60) @(posedge clk);
    check("standby", 64'h0, standby);
    repeat (60) @(posedge clk);
    check("standby", 64'h1, standby);
    mcu_master_inst.pins(1'b1, 1'b1);
    repeat (8) @(posedge clk);
    check("standby", 64'h0, standby);
  end
  endtask
  task test_frames;
    reg [63:0] wd, rd, exp;
    integer    i, j;
  begin
    for (j = 0; j < 4; j = j + 1)
    begin
      exp = 64'h0;
      for (i = 0; i < 8; i = i + 1)
      begin
        wd[8*i +: 8] = 8'h96 + 8'h25 * i + j;
        if (i < (1 << j))
          exp[8*i +: 8] = wd[8*i +: 8];
      end
      // the four-byte frame runs past the top address and wraps
      mcu_master_inst.frame(1'b0, j, 5'h1a + 2 * j, wd, rd);
      check("serial", 64'h0, serial_mode);
      check("busy", 64'h0, busy);
      mcu_master_inst.frame(1'b1, j, 5'h1a + 2 * j, 64'h0, rd);
      check("read", exp, rd);
      check("oe", 64'h0, tx_pin_oe);
      if (j == 2)
      begin
        mcu_master_inst.frame(1'b1, 2'h0, 5'h00, 64'h0, rd);
        check("wrap", {56'h0, wd[23:16]}, rd);
      end
    end
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    test_modes;
    test_frames;
    summarize;
  end
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
endmodule
